// ===== brc_pkg.sv
// package for the boot, reset and pin-monitor block
// assumes a 100 MHz system clock and no register bus
package brc_pkg;
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned GASP_DEADLINE_MS = 75;
    localparam int unsigned GASP_DEADLINE_CYC =
        (GASP_DEADLINE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned GASP_CNT_W       = 23;
    localparam int unsigned DSM_W            = 12;
    localparam logic [11:0] DSM_TUNE_RESET   = 12'h800;
    localparam logic [2:0]  SYNC_RESET       = 3'h7;
    localparam logic        SYNC_LOW_RESET   = 1'b0;
    localparam int unsigned N_SYNC           = 6;
    // cycles after reset before synchronised pins are valid
    localparam int unsigned SYNC_FILL_CYC    = 4;
    localparam int unsigned IDX_RST          = 0;
    localparam int unsigned IDX_DEF          = 1;
    localparam int unsigned IDX_GASP         = 2;
    localparam int unsigned IDX_WAKE         = 3;
    localparam int unsigned IDX_IRQ0         = 4;
    localparam int unsigned IDX_IRQ1         = 5;

    typedef enum logic [2:0] {
        BRC_BOOT_ROM   = 3'h1,
        BRC_BOOT_FLASH = 3'h2,
        BRC_BOOT_PROG  = 3'h4
    } brc_boot_t;

    typedef enum logic [3:0] {
        BRC_ST_RESET = 4'h1,
        BRC_ST_RUN   = 4'h2,
        BRC_ST_GASP  = 4'h4,
        BRC_ST_DEAD  = 4'h8
    } brc_state_t;

    typedef struct packed {
        logic defaults_req;
        logic gasp_active;
        logic gasp_expired;
        logic wake_req;
        logic irq0_req;
        logic irq1_req;
    } brc_events_t;
endpackage

// ===== brc_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes the pin is asynchronous to i_clk_sys
`timescale 1ns/100ps
module brc_sync
    import brc_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_pin,
    output logic      o_level
);
    logic [2:0] stage_reg;
    logic       level_reg;
    logic       agree;

    assign agree = (stage_reg[1] == stage_reg[2]);

    // only stage 1 reads stage 0
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            stage_reg <= SYNC_RESET;
            level_reg <= 1'b1;
        end else begin
            stage_reg <= {stage_reg[1:0], i_pin};
            if (agree)
                level_reg <= stage_reg[2];
        end
    end

    assign o_level = level_reg;
endmodule

// ===== brc_tune_dsm.sv
// first-order delta-sigma modulator for the oscillator tune output
// assumes a filter on the board integrates the bit stream
`timescale 1ns/100ps
module brc_tune_dsm
    import brc_pkg::*;
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_b,
    input  wire logic [DSM_W-1:0] i_level,
    output logic                  o_bit
);
    logic [DSM_W:0] acc_reg;
    logic [DSM_W:0] acc_next;
    logic           bit_reg;

    assign acc_next = {1'b0, acc_reg[DSM_W-1:0]} + {1'b0, i_level};

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            acc_reg <= '0;
            bit_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            bit_reg <= acc_next[DSM_W];
        end
    end

    assign o_bit = bit_reg;
endmodule

// ===== brc_boot_reset_control.sv
// boot-source latch, reset and pin monitor top module
// assumes pins arrive asynchronously; i_rst_b is the power-on reset
`timescale 1ns/100ps
// Functional notes
// R01 - reference clock comes from an external tuned crystal oscillator
// R02 - drive oversampled bit stream as oscillator tune voltage
// R03 - floating boot input selects internal ROM boot
// R04 - boot input pulled to ground selects external flash boot
// R05 - boot input high at power-up starts flash programming mode
// R06 - low hard reset input resets whole device
// R07 - low restore input requests factory default settings
// R08 - power-loss high starts shutdown, must finish within 75 ms
// R09 - drive front-end reset low to reset front end, power down driver
// R10 - low front-end wake input is a wake request
// R11 - either low serial interrupt input requests service
// R12 - sample boot level once at reset release, hold until reset
// R13 - synchronise reset, restore, power-loss, wake inputs before use
module brc_boot_reset_control
    import brc_pkg::*;
#(
    parameter int unsigned GASP_LIMIT = GASP_DEADLINE_CYC
)
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_b,
    input  wire logic             i_hard_reset_n,
    input  wire logic             i_boot_driven,
    input  wire logic             i_boot_level,
    input  wire logic             i_restore_defaults_n,
    input  wire logic             i_power_loss,
    input  wire logic             i_frontend_wake_n,
    input  wire logic             i_serial_irq0_n,
    input  wire logic             i_serial_irq1_n,
    input  wire logic [DSM_W-1:0] i_tune_level,
    input  wire logic             i_shutdown_done,
    output logic                  o_osc_tune_out,
    output brc_boot_t             o_boot_source,
    output logic                  o_core_reset_n,
    output logic                  o_frontend_reset_n,
    output brc_events_t           o_events
);
    logic [N_SYNC-1:0] pin_raw;
    logic [N_SYNC-1:0] pin_sync;
    brc_state_t        state_reg;
    brc_state_t        state_next;
    brc_boot_t         boot_reg;
    brc_boot_t         boot_decoded;
    logic              rst_seen_reg;
    logic [GASP_CNT_W-1:0] gasp_cnt_reg;
    logic              core_rst_n_reg;
    logic              fe_rst_n_reg;
    brc_events_t       ev_reg;
    brc_events_t       ev_next;
    logic              hard_rst_low;
    logic              gasp_high;
    logic              gasp_timeout;
    logic              release_edge;
    logic [2:0]        boot_sync_reg;
    logic [2:0]        drv_sync_reg;
    logic              boot_lvl;
    logic              boot_drv;
    logic              boot_lvl_reg;
    logic              boot_drv_reg;
    logic              boot_agree;
    logic              drv_agree;
    logic [SYNC_FILL_CYC-1:0] fill_reg;
    logic              sync_ready;

    assign pin_raw[IDX_RST]  = i_hard_reset_n;
    assign pin_raw[IDX_DEF]  = i_restore_defaults_n;
    assign pin_raw[IDX_GASP] = ~i_power_loss;
    assign pin_raw[IDX_WAKE] = i_frontend_wake_n;
    assign pin_raw[IDX_IRQ0] = i_serial_irq0_n;
    assign pin_raw[IDX_IRQ1] = i_serial_irq1_n;

    // pins synchronised before use
    genvar g;
    generate
        for (g = 0; g < N_SYNC; g++) begin : g_sync
            brc_sync u_sync (
                .i_clk_sys (i_clk_sys),
                .i_rst_b   (i_rst_b),
                .i_pin     (pin_raw[g]),
                .o_level   (pin_sync[g])
            ); // R13
        end
    endgenerate

    // oscillator tune bit stream
    brc_tune_dsm u_dsm (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_level   (i_tune_level),
        .o_bit     (o_osc_tune_out)
    ); // R02

    function automatic brc_boot_t decode_boot(input logic drv,
                                              input logic lvl);
        if (!drv)
            decode_boot = BRC_BOOT_ROM; // R03
        else if (lvl)
            decode_boot = BRC_BOOT_PROG; // R05
        else
            decode_boot = BRC_BOOT_FLASH; // R04
    endfunction

    assign hard_rst_low = ~pin_sync[IDX_RST]; // R06
    assign gasp_high    = ~pin_sync[IDX_GASP];
    assign boot_agree   = (boot_sync_reg[1] == boot_sync_reg[2]);
    assign drv_agree    = (drv_sync_reg[1] == drv_sync_reg[2]);
    assign sync_ready   = fill_reg[SYNC_FILL_CYC-1];
    assign boot_lvl     = boot_lvl_reg;
    assign boot_drv     = boot_drv_reg;
    assign boot_decoded = decode_boot(boot_drv, boot_lvl);
    // no release until every synchroniser holds a real pin value
    assign release_edge = (state_reg == BRC_ST_RESET) && sync_ready
                          && !hard_rst_low;
    assign gasp_timeout = (gasp_cnt_reg >= GASP_CNT_W'(GASP_LIMIT - 1));

    // boot strap synchronisers, taken once stages 1 and 2 agree
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            boot_sync_reg <= 3'h0;
            drv_sync_reg  <= 3'h0;
            boot_lvl_reg  <= 1'b0;
            boot_drv_reg  <= 1'b0;
            fill_reg      <= '0;
        end else begin
            boot_sync_reg <= {boot_sync_reg[1:0], i_boot_level};
            drv_sync_reg  <= {drv_sync_reg[1:0], i_boot_driven};
            fill_reg      <= {fill_reg[SYNC_FILL_CYC-2:0], 1'b1}; // R13
            if (boot_agree)
                boot_lvl_reg <= boot_sync_reg[2];
            if (drv_agree)
                boot_drv_reg <= drv_sync_reg[2];
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BRC_ST_RESET: begin
                if (sync_ready && !hard_rst_low)
                    state_next = BRC_ST_RUN; // R12
            end
            BRC_ST_RUN: begin
                if (hard_rst_low)
                    state_next = BRC_ST_RESET;
                else if (gasp_high)
                    state_next = BRC_ST_GASP; // R08
            end
            BRC_ST_GASP: begin
                if (hard_rst_low)
                    state_next = BRC_ST_RESET;
                else if (i_shutdown_done || gasp_timeout)
                    state_next = BRC_ST_DEAD; // R08
            end
            BRC_ST_DEAD: begin
                if (hard_rst_low)
                    state_next = BRC_ST_RESET;
            end
            default: state_next = BRC_ST_RESET;
        endcase
    end

    always_comb begin
        ev_next.defaults_req = ~pin_sync[IDX_DEF]; // R07
        ev_next.gasp_active  = (state_next == BRC_ST_GASP);
        ev_next.gasp_expired = (state_next == BRC_ST_DEAD);
        ev_next.wake_req     = ~pin_sync[IDX_WAKE]; // R10
        ev_next.irq0_req     = ~pin_sync[IDX_IRQ0]; // R11
        ev_next.irq1_req     = ~pin_sync[IDX_IRQ1]; // R11
        if (state_next == BRC_ST_RESET)
            ev_next = '0;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            state_reg      <= BRC_ST_RESET;
            rst_seen_reg   <= 1'b0;
            boot_reg       <= BRC_BOOT_ROM;
            gasp_cnt_reg   <= '0;
            core_rst_n_reg <= 1'b0;
            fe_rst_n_reg   <= 1'b0;
            ev_reg         <= '0;
        end else begin
            state_reg      <= state_next;
            ev_reg         <= ev_next;
            core_rst_n_reg <= (state_next != BRC_ST_RESET); // R06
            // front end held in reset outside run
            fe_rst_n_reg   <= (state_next == BRC_ST_RUN); // R09
            if (state_reg == BRC_ST_GASP)
                gasp_cnt_reg <= gasp_cnt_reg + 1'b1;
            else
                gasp_cnt_reg <= '0;
            if (state_next == BRC_ST_RESET)
                rst_seen_reg <= 1'b0;
            else if (release_edge && !rst_seen_reg) begin
                boot_reg     <= boot_decoded; // R12
                rst_seen_reg <= 1'b1;
            end
        end
    end

    assign o_boot_source      = boot_reg;
    assign o_core_reset_n     = core_rst_n_reg;
    assign o_frontend_reset_n = fe_rst_n_reg;
    assign o_events           = ev_reg;

    property p_gasp_bound;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_reg == BRC_ST_GASP) |-> (gasp_cnt_reg < GASP_LIMIT);
    endproperty
    a_gasp_bound: assert property (p_gasp_bound) // R08
        else $error("power-loss handling overran its deadline");

    property p_gasp_enter;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_reg == BRC_ST_RUN && gasp_high && !hard_rst_low)
            |=> o_events.gasp_active && !o_frontend_reset_n;
    endproperty
    a_gasp_enter: assert property (p_gasp_enter) // R08
        else $error("power loss not flagged next cycle");

    property p_reset_all;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        hard_rst_low |=> !o_core_reset_n && !o_frontend_reset_n
            && o_events == '0;
    endproperty
    a_reset_all: assert property (p_reset_all) // R06
        else $error("hard reset did not reset the device");

    property p_fe_run;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_reg == BRC_ST_RUN) |-> o_frontend_reset_n;
    endproperty
    a_fe_run: assert property (p_fe_run) // R09
        else $error("front end held in reset while running");

    property p_boot_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (rst_seen_reg && $past(rst_seen_reg)) |-> $stable(o_boot_source);
    endproperty
    a_boot_hold: assert property (p_boot_hold) // R12
        else $error("boot source changed without reset");

    property p_boot_take;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (release_edge && !rst_seen_reg)
            |=> o_boot_source == $past(boot_decoded);
    endproperty
    a_boot_take: assert property (p_boot_take) // R12
        else $error("boot source not captured at release");

    property p_defaults;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (!pin_sync[IDX_DEF] && state_next != BRC_ST_RESET)
            |=> o_events.defaults_req;
    endproperty
    a_defaults: assert property (p_defaults) // R07
        else $error("restore request missed");

    property p_wake_irq;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_next == BRC_ST_RUN && !pin_sync[IDX_WAKE]
            && !pin_sync[IDX_IRQ0]) |=> o_events.wake_req && o_events.irq0_req;
    endproperty
    a_wake_irq: assert property (p_wake_irq) // R10 R11
        else $error("wake or serial request missed");

    property p_sync_wait;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !sync_ready |=> !o_core_reset_n;
    endproperty
    a_sync_wait: assert property (p_sync_wait) // R13
        else $error("reset released before pins were synchronised");

    property p_gasp_expire;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_reg == BRC_ST_GASP && gasp_timeout && !hard_rst_low)
            |=> o_events.gasp_expired && !o_events.gasp_active;
    endproperty
    a_gasp_expire: assert property (p_gasp_expire) // R08
        else $error("power-loss deadline did not end handling");

    property p_dead_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_reg == BRC_ST_DEAD && !hard_rst_low)
            |=> o_events.gasp_expired && !o_frontend_reset_n;
    endproperty
    a_dead_hold: assert property (p_dead_hold) // R08
        else $error("expired state left without reset");

    property p_fe_idle;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_reg != BRC_ST_RUN) |-> !o_frontend_reset_n;
    endproperty
    a_fe_idle: assert property (p_fe_idle) // R09
        else $error("front end out of reset while not running");

    property p_core_run;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_reg == BRC_ST_RUN) |-> o_core_reset_n;
    endproperty
    a_core_run: assert property (p_core_run) // R06
        else $error("core held in reset while running");

    property p_irq1;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (state_next != BRC_ST_RESET && !pin_sync[IDX_IRQ1])
            |=> o_events.irq1_req;
    endproperty
    a_irq1: assert property (p_irq1) // R11
        else $error("second serial request missed");

    c_gasp:  cover property (@(posedge i_clk_sys) state_reg == BRC_ST_GASP);
    c_dead:  cover property (@(posedge i_clk_sys) state_reg == BRC_ST_DEAD);
    c_prog:  cover property (@(posedge i_clk_sys)
        o_boot_source == BRC_BOOT_PROG);
    c_flash: cover property (@(posedge i_clk_sys)
        o_boot_source == BRC_BOOT_FLASH);
endmodule

// ===== brc_board_model.sv
// board model: reset network, strap, switch, power-fail detector, wake
// assumes the bench sets its intents just after the falling clock edge
`timescale 1ns/100ps
module brc_board_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rc_low,
    input  wire logic [1:0] i_strap,
    input  wire logic [4:0] i_ask,
    output logic            o_hard_reset_n,
    output logic            o_boot_driven,
    output logic            o_boot_level,
    output logic [4:0]      o_pins
);
    logic float_reg = 1'b0;
    // open strap pin wanders every cycle
    always @(negedge i_clk_sys) float_reg <= ~float_reg;
    assign o_hard_reset_n = ~i_rc_low;
    assign o_boot_driven  = i_strap[1];
    assign o_boot_level   = i_strap[1] ? i_strap[0] : float_reg;
    // pins {restore_n, loss, wake_n, irq0_n, irq1_n}; loss low when idle
    assign o_pins[4]      = ~i_ask[4];
    assign o_pins[3]      = i_ask[3];
    assign o_pins[2]      = ~i_ask[2];
    assign o_pins[1:0]    = ~i_ask[1:0];
endmodule

// ===== testbench.sv
// self-checking bench for the boot, reset and pin-monitor block
// assumes the board model drives every pin; gasp limit shortened to 50
`timescale 1ns/100ps
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin \
    err_count++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module testbench;
    import brc_pkg::*;
    localparam int unsigned LIM = 50;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        rc_low = 1'b0;
    logic [1:0]  strap = 2'b10;
    logic [4:0]  ask = 5'h00;
    logic [11:0] lvl = 12'h000;
    logic        sd_done = 1'b0;
    wire         hard_n, bdrv, blvl, tune, core_n, fe_n;
    wire  [4:0]  pins;
    brc_boot_t   boot;
    brc_events_t ev;
    int          err_count = 0;
    int          samples_checked = 0;
    int          seed = 32'hff4b9636;
    int          cnt;
    initial forever #5 clk = ~clk;
    brc_board_model u_board (.i_clk_sys(clk), .i_rc_low(rc_low),
        .i_strap(strap), .i_ask(ask), .o_hard_reset_n(hard_n),
        .o_boot_driven(bdrv), .o_boot_level(blvl), .o_pins(pins));
    brc_boot_reset_control #(.GASP_LIMIT(LIM)) u_dut (.i_clk_sys(clk),
        .i_rst_b(rst_b), .i_hard_reset_n(hard_n), .i_boot_driven(bdrv),
        .i_boot_level(blvl), .i_restore_defaults_n(pins[4]),
        .i_power_loss(pins[3]), .i_frontend_wake_n(pins[2]),
        .i_serial_irq0_n(pins[1]), .i_serial_irq1_n(pins[0]),
        .i_tune_level(lvl), .i_shutdown_done(sd_done),
        .o_osc_tune_out(tune), .o_boot_source(boot),
        .o_core_reset_n(core_n), .o_frontend_reset_n(fe_n), .o_events(ev));
    function automatic brc_boot_t exp_boot(input logic [1:0] s);
        if (!s[1]) return BRC_BOOT_ROM;
        return s[0] ? BRC_BOOT_PROG : BRC_BOOT_FLASH;
    endfunction
    function automatic logic [5:0] exp_ev(input logic [4:0] a);
        return {a[4], 2'b00, a[2], a[1], a[0]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // pulse the board reset with a given strap, then release
    task automatic hard(input logic [1:0] s);
        rc_low = 1'b1;
        strap = s;
        cyc(10);
        `CHK(core_n, 1'b0, "core reset")
        `CHK(fe_n, 1'b0, "front end reset")
        `CHK(ev, 6'h00, "events in reset")
        rc_low = 1'b0;
        cyc(10);
        `CHK(core_n, 1'b1, "core release")
    endtask
    // count tune ones over one accumulator wrap
    task automatic tune_run(input logic [11:0] l);
        lvl = l;
        cyc(16);
        cnt = 0;
        repeat (4096) begin
            @(negedge clk);
            cnt += int'(tune);
        end
        `CHK(cnt >= int'(l) - 2 && cnt <= int'(l) + 2, 1'b1, "tune")
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        test_done();
    end
    initial begin
        cyc(12);
        `CHK(boot, BRC_BOOT_ROM, "boot in reset")
        `CHK(core_n, 1'b0, "core in reset")
        rst_b = 1'b1;
        cyc(2);
        `CHK(core_n, 1'b0, "early release")
        cyc(8);
        `CHK(boot, BRC_BOOT_FLASH, "power-up strap")
        for (int i = 0; i < 3; i++) begin
            hard(i == 0 ? 2'b00 : (i == 1 ? 2'b10 : 2'b11));
            `CHK(boot, exp_boot(strap), "boot source")
            strap = strap ^ 2'b11;
            cyc(10);
            `CHK(boot, exp_boot(strap ^ 2'b11), "boot held")
        end
        for (int i = 0; i < 30; i++) begin
            ask = 5'($random(seed)) & 5'h17;
            cyc(8);
            `CHK(ev, exp_ev(ask), "pin events")
        end
        ask = 5'h00;
        cyc(8);
        ask = 5'h17;
        cyc(1);
        ask = 5'h00;
        cyc(1);
        ask = 5'h17;
        cyc(1);
        ask = 5'h00;
        repeat (6) begin
            cyc(1);
            `CHK(ev, 6'h00, "glitch passed")
        end
        ask = 5'h08;
        cyc(6);
        `CHK(ev.gasp_active, 1'b1, "gasp start")
        `CHK(fe_n, 1'b0, "front end off")
        cyc(30);
        `CHK(ev.gasp_expired, 1'b0, "early expiry")
        cyc(30);
        `CHK(ev.gasp_expired, 1'b1, "deadline")
        ask = 5'h00;
        cyc(8);
        `CHK(ev.gasp_expired, 1'b1, "expiry held")
        hard(2'b10);
        ask = 5'h08;
        cyc(6);
        sd_done = 1'b1;
        cyc(1);
        sd_done = 1'b0;
        cyc(4);
        `CHK(ev.gasp_active, 1'b0, "shutdown done")
        `CHK(ev.gasp_expired, 1'b1, "done ends handling")
        `CHK(fe_n, 1'b0, "front end kept off")
        ask = 5'h00;
        hard(2'b10);
        `CHK(fe_n, 1'b1, "front end on")
        tune_run(12'h000);
        tune_run(12'hFFF);
        tune_run(12'($random(seed)));
        test_done();
    end
endmodule
